// ===== rtl/ssg_pkg.sv
// shared constants and types for the serial slave group and error monitor
package ssg_pkg;
  localparam logic [15:0] GROUP_HIGH_OFFSET = 16'h0030;
  localparam logic [15:0] GROUP_LOW_OFFSET = 16'h0031;
  localparam logic [31:0] GROUP_NONE = 32'hFFFFFFFF;
  localparam logic [31:0] GROUP_MAX = 32'h0000001F;
  localparam logic [7:0] FUNC_WRITE_MULTI = 8'h10;
  localparam logic [7:0] EXC_ILLEGAL_FUNC = 8'h01;
  localparam logic [7:0] EXC_ILLEGAL_ADDR = 8'h02;
  localparam logic [7:0] EXC_ILLEGAL_VALUE = 8'h03;
  localparam logic [7:0] EXC_DEVICE_FAIL = 8'h04;
  localparam logic [7:0] ERR_TRANSMISSION = 8'h84;
  localparam logic [7:0] ERR_UNDEFINED = 8'h88;
  localparam logic [7:0] ERR_BUSY_IF = 8'h89;
  localparam logic [7:0] ERR_BUSY_NVM = 8'h8A;
  localparam logic [7:0] ERR_RANGE = 8'h8C;
  localparam logic [7:0] ERR_DISABLED = 8'h8D;
  localparam logic [7:0] ALM_SWITCH = 8'h83;
  localparam logic [7:0] ALM_TRANSMISSION = 8'h84;
  localparam logic [7:0] ALM_TIMEOUT = 8'h85;
  localparam logic [7:0] ALM_NONE = 8'h00;
  localparam logic [3:0] BAUD_MAX_CODE = 4'h5;
  localparam int CLK_HZ = 40000000;
  localparam int ACTION_EXTRA_US = 2000;
  localparam int ACTION_EXTRA_CYC = ACTION_EXTRA_US * (CLK_HZ / 1000000);
  localparam int BLINK_MS = 250;
  localparam int BLINK_CYC = BLINK_MS * (CLK_HZ / 1000);
  localparam int BLINK_FLASHES = 2;
  localparam int LOG_DEPTH = 10;
  localparam int TIMEOUT_MS = 200;
  localparam int TIMEOUT_CYC = TIMEOUT_MS * (CLK_HZ / 1000);

  typedef enum logic [1:0] {
    SSG_IDLE = 2'b00,
    SSG_WAIT = 2'b01,
    SSG_SEND = 2'b10
  } ssg_reply_t;

  // one decoded query from the frame receiver
  typedef struct packed {
    logic valid;
    logic [7:0] station;
    logic [7:0] func;
    logic [15:0] regAddr;
    logic [15:0] regCount;
    logic [31:0] data;
    logic isWrite;
    logic action;
  } ssg_query_t;

  // outcome reported by the command executor
  typedef struct packed {
    logic valid;
    logic exception;
    logic [7:0] excCode;
    logic nvmBusy;
    logic ifBusy;
    logic cmdDisabled;
  } ssg_result_t;

  typedef struct packed {
    logic commRed;
    logic pwrRed;
    logic pwrGreen;
  } ssg_leds_t;
endpackage

// ===== rtl/ssg_monitor.sv
// slave group addressing, reply timing, error log and comm alarms
`timescale 1ns/10ps
// Function
// - group holds -1 or parent address 1..31
// - group reloads initial value at power-up
// - non-volatile initial group loaded at power-up
// - transmission error: comm red, power flashes twice
// - other error codes light no indicator
// - exceptions logged as mapped error codes
// - error history empty after power-up
// - alarm drops output, stops motor, flashes red
// - bad rate switch raises alarm 83h
// - consecutive transmission errors raise alarm 84h
// - communication timeout raises alarm 85h
// - reply waits wait time plus silent interval
// - actions applied within silent plus 2 ms
// - child executes group query without reply
// - group execution only for function 10h
module ssg_monitor (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [7:0] stationAddr,
  input wire logic [31:0] initialGroup,
  input wire logic [3:0] baudSwitch,
  input wire logic [7:0] errThreshold,
  input wire logic [31:0] timeoutCycles,
  input wire logic [31:0] silentCycles,
  input wire logic [31:0] replyWaitCycles,
  input wire ssg_pkg::ssg_query_t query,
  input wire logic txError,
  input wire ssg_pkg::ssg_result_t result,
  input wire logic [3:0] logIndex,
  output logic execute,
  output logic replyEnable,
  output logic rangeReject,
  output logic actionApply,
  output logic [31:0] groupId,
  output logic [7:0] logData,
  output logic [3:0] logCount,
  output logic [7:0] alarmCode,
  output logic alarmOutput,
  output logic motorStop,
  output ssg_pkg::ssg_leds_t leds
);
  logic [31:0] group_q, group_d;
  logic exec_q, exec_d;
  logic reject_q, reject_d;
  logic pendReply_q, pendReply_d;
  ssg_pkg::ssg_reply_t state_q, state_d;
  logic [31:0] waitCnt_q, waitCnt_d;
  logic replyEn_q, replyEn_d;
  logic [31:0] actCnt_q, actCnt_d;
  logic act_q, act_d;
  logic [7:0] log_q [ssg_pkg::LOG_DEPTH];
  logic [7:0] log_d [ssg_pkg::LOG_DEPTH];
  logic [3:0] logCnt_q, logCnt_d;
  logic [7:0] logOut_q, logOut_d;
  logic [7:0] errRun_q, errRun_d;
  logic [31:0] toCnt_q, toCnt_d;
  logic [7:0] alarm_q, alarm_d;
  logic [31:0] blinkCnt_q, blinkCnt_d;
  logic [2:0] phase_q, phase_d;
  ssg_pkg::ssg_leds_t leds_q, leds_d;
  logic loaded_q, alarmOut_q, alarmOut_d, stop_q, stop_d;

  logic toMe, toGroup, groupWrite, validGroup;
  logic [7:0] newErr;
  logic newErrValid;

  always_comb begin
    toMe = query.valid && query.station == stationAddr;
    toGroup = query.valid && group_q != ssg_pkg::GROUP_NONE &&
      query.station == group_q[7:0] && !toMe;
    groupWrite = toMe && query.isWrite &&
      query.regAddr == ssg_pkg::GROUP_HIGH_OFFSET &&
      query.regCount == 16'h0002;
    validGroup = query.data == ssg_pkg::GROUP_NONE ||
      (query.data != 32'h00000000 &&
      query.data <= ssg_pkg::GROUP_MAX);
    group_d = group_q;
    reject_d = 1'b0;
    if (groupWrite) begin
      if (validGroup) begin
        group_d = query.data;
      end else begin
        reject_d = 1'b1;
      end
    end
    if (!loaded_q) begin
      group_d = initialGroup;
    end
    exec_d = toMe ||
      (toGroup && query.func == ssg_pkg::FUNC_WRITE_MULTI);
    pendReply_d = pendReply_q;
    if (toMe) begin
      pendReply_d = 1'b1;
    end else if (state_q == ssg_pkg::SSG_SEND) begin
      pendReply_d = 1'b0;
    end
  end

  always_comb begin
    state_d = state_q;
    waitCnt_d = waitCnt_q;
    replyEn_d = 1'b0;
    case (state_q)
      ssg_pkg::SSG_IDLE: begin
        if (pendReply_q) begin
          state_d = ssg_pkg::SSG_WAIT;
          waitCnt_d = replyWaitCycles + silentCycles;
        end
      end
      ssg_pkg::SSG_WAIT: begin
        if (waitCnt_q <= 32'h00000001) begin
          state_d = ssg_pkg::SSG_SEND;
        end else begin
          waitCnt_d = waitCnt_q - 32'h00000001;
        end
      end
      ssg_pkg::SSG_SEND: begin
        replyEn_d = 1'b1;
        state_d = ssg_pkg::SSG_IDLE;
      end
      default: state_d = ssg_pkg::SSG_IDLE;
    endcase
    act_d = 1'b0;
    actCnt_d = actCnt_q;
    if (exec_d && query.action) begin
      actCnt_d = silentCycles + 32'(ssg_pkg::ACTION_EXTRA_CYC);
    end else if (actCnt_q == 32'h00000001) begin
      act_d = 1'b1;
      actCnt_d = 32'h00000000;
    end else if (actCnt_q != 32'h00000000) begin
      actCnt_d = actCnt_q - 32'h00000001;
    end
  end

  always_comb begin
    newErrValid = 1'b1;
    newErr = ssg_pkg::ERR_TRANSMISSION;
    if (txError) begin
      newErr = ssg_pkg::ERR_TRANSMISSION;
    end else if (result.valid && result.exception) begin
      if (result.nvmBusy) begin
        newErr = ssg_pkg::ERR_BUSY_NVM;
      end else if (result.ifBusy) begin
        newErr = ssg_pkg::ERR_BUSY_IF;
      end else if (result.cmdDisabled) begin
        newErr = ssg_pkg::ERR_DISABLED;
      end else if (result.excCode == ssg_pkg::EXC_ILLEGAL_FUNC ||
        result.excCode == ssg_pkg::EXC_ILLEGAL_ADDR) begin
        newErr = ssg_pkg::ERR_UNDEFINED;
      end else begin
        newErr = ssg_pkg::ERR_RANGE;
      end
    end else if (reject_q) begin
      newErr = ssg_pkg::ERR_RANGE;
    end else begin
      newErrValid = 1'b0;
    end
    for (int i = 0; i < ssg_pkg::LOG_DEPTH; i++) begin
      log_d[i] = log_q[i];
    end
    logCnt_d = logCnt_q;
    if (newErrValid) begin
      log_d[0] = newErr;
      for (int i = 1; i < ssg_pkg::LOG_DEPTH; i++) begin
        log_d[i] = log_q[i - 1];
      end
      if (logCnt_q < 4'(ssg_pkg::LOG_DEPTH)) begin
        logCnt_d = logCnt_q + 4'h1;
      end
    end
    logOut_d = 8'h00;
    if (logIndex < logCnt_q) begin
      logOut_d = log_q[logIndex];
    end
  end

  always_comb begin
    errRun_d = errRun_q;
    if (txError) begin
      if (errRun_q != 8'hFF) begin
        errRun_d = errRun_q + 8'h01;
      end
    end else if (query.valid) begin
      errRun_d = 8'h00;
    end
    toCnt_d = query.valid ? 32'h00000000 :
      (toCnt_q == 32'hFFFFFFFF ? toCnt_q : toCnt_q + 32'h00000001);
    alarm_d = alarm_q;
    if (alarm_q == ssg_pkg::ALM_NONE) begin
      if (baudSwitch > ssg_pkg::BAUD_MAX_CODE) begin
        alarm_d = ssg_pkg::ALM_SWITCH;
      end else if (errThreshold != 8'h00 && errRun_d >= errThreshold) begin
        alarm_d = ssg_pkg::ALM_TRANSMISSION;
      end else if (timeoutCycles != 32'h00000000 &&
        toCnt_q >= timeoutCycles) begin
        alarm_d = ssg_pkg::ALM_TIMEOUT;
      end
    end
    alarmOut_d = alarm_d == ssg_pkg::ALM_NONE;
    stop_d = alarm_d != ssg_pkg::ALM_NONE;
  end

  always_comb begin
    blinkCnt_d = blinkCnt_q;
    phase_d = phase_q;
    leds_d = leds_q;
    if (txError) begin
      leds_d.commRed = 1'b1;
      phase_d = 3'(2 * ssg_pkg::BLINK_FLASHES);
      blinkCnt_d = 32'(ssg_pkg::BLINK_CYC);
    end else if (query.valid) begin
      leds_d.commRed = 1'b0;
    end
    // alarm keeps the phase running so red blinks until reset
    if (!txError && (phase_q != 3'h0 || alarm_q != ssg_pkg::ALM_NONE)) begin
      if (blinkCnt_q == 32'h00000000) begin
        phase_d = phase_q - 3'h1;
        blinkCnt_d = 32'(ssg_pkg::BLINK_CYC);
      end else begin
        blinkCnt_d = blinkCnt_q - 32'h00000001;
      end
    end
    leds_d.pwrRed = phase_q[0];
    leds_d.pwrGreen = phase_q[0] && alarm_q == ssg_pkg::ALM_NONE;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      group_q <= ssg_pkg::GROUP_NONE;
      exec_q <= 1'b0;
      reject_q <= 1'b0;
      pendReply_q <= 1'b0;
      state_q <= ssg_pkg::SSG_IDLE;
      waitCnt_q <= 32'h00000000;
      replyEn_q <= 1'b0;
      actCnt_q <= 32'h00000000;
      act_q <= 1'b0;
      for (int i = 0; i < ssg_pkg::LOG_DEPTH; i++) begin
        log_q[i] <= 8'h00;
      end
      logCnt_q <= 4'h0;
      logOut_q <= 8'h00;
      errRun_q <= 8'h00;
      toCnt_q <= 32'h00000000;
      alarm_q <= ssg_pkg::ALM_NONE;
      blinkCnt_q <= 32'h00000000;
      phase_q <= 3'h0;
      leds_q <= '0;
      loaded_q <= 1'b0;
      alarmOut_q <= 1'b1;
      stop_q <= 1'b0;
    end else begin
      group_q <= group_d;
      exec_q <= exec_d;
      reject_q <= reject_d;
      pendReply_q <= pendReply_d;
      state_q <= state_d;
      waitCnt_q <= waitCnt_d;
      replyEn_q <= replyEn_d;
      actCnt_q <= actCnt_d;
      act_q <= act_d;
      log_q <= log_d;
      logCnt_q <= logCnt_d;
      logOut_q <= logOut_d;
      errRun_q <= errRun_d;
      toCnt_q <= toCnt_d;
      alarm_q <= alarm_d;
      blinkCnt_q <= blinkCnt_d;
      phase_q <= phase_d;
      leds_q <= leds_d;
      loaded_q <= 1'b1;
      alarmOut_q <= alarmOut_d;
      stop_q <= stop_d;
    end
  end

  assign execute = exec_q;
  assign replyEnable = replyEn_q;
  assign rangeReject = reject_q;
  assign actionApply = act_q;
  assign groupId = group_q;
  assign logData = logOut_q;
  assign logCount = logCnt_q;
  assign alarmCode = alarm_q;
  assign alarmOutput = alarmOut_q;
  assign motorStop = stop_q;
  assign leds = leds_q;
endmodule

// ===== sim/ssg_monitor_props.sv
// port assertions for the group and alarm monitor
`timescale 1ns/10ps
module ssg_monitor_props (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [7:0] stationAddr,
  input wire logic [31:0] initialGroup,
  input wire logic [3:0] baudSwitch,
  input wire logic [7:0] errThreshold,
  input wire logic [31:0] timeoutCycles,
  input wire logic [31:0] silentCycles,
  input wire logic [31:0] replyWaitCycles,
  input wire ssg_pkg::ssg_query_t query,
  input wire logic txError,
  input wire ssg_pkg::ssg_result_t result,
  input wire logic [3:0] logIndex,
  input wire logic execute,
  input wire logic replyEnable,
  input wire logic rangeReject,
  input wire logic actionApply,
  input wire logic [31:0] groupId,
  input wire logic [7:0] logData,
  input wire logic [3:0] logCount,
  input wire logic [7:0] alarmCode,
  input wire logic alarmOutput,
  input wire logic motorStop,
  input wire ssg_pkg::ssg_leds_t leds
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic uni;
  logic grp;
  assign uni = query.valid && query.station == stationAddr;
  assign grp = query.valid && groupId != ssg_pkg::GROUP_NONE &&
    query.station == groupId[7:0] && !uni;
  a_reset_group: assert property (disable iff (1'b0) rst |=>
    groupId == ssg_pkg::GROUP_NONE) else $error("group not cleared");
  a_reset_log: assert property (disable iff (1'b0) rst |=>
    logCount == 4'h0) else $error("log not empty");
  a_alarm_pins: assert property (motorStop != alarmOutput &&
    alarmOutput == (alarmCode == ssg_pkg::ALM_NONE))
    else $error("alarm pins wrong");
  a_alarm_hold: assert property (alarmCode != ssg_pkg::ALM_NONE |=>
    $stable(alarmCode)) else $error("alarm not latched");
  a_exec_unicast: assert property (uni && !query.isWrite |=>
    execute) else $error("unicast not executed");
  a_group_exec: assert property (grp && query.func == 8'h10 |=>
    execute) else $error("group write not executed");
  a_group_func: assert property (grp && query.func != 8'h10 |=>
    !execute) else $error("group query wrongly executed");
  a_tx_led: assert property (txError |-> ##[1:4] leds.commRed)
    else $error("comm led not lit");
  a_flash_pair: assert property (alarmCode == ssg_pkg::ALM_NONE |->
    leds.pwrRed == leds.pwrGreen) else $error("power flash unpaired");
  a_switch_alarm: assert property (baudSwitch > 4'h5 |->
    ##[1:4] alarmCode == ssg_pkg::ALM_SWITCH) else $error("no alarm 83");
  a_reject_keep: assert property (uni && query.isWrite &&
    query.data == 32'h0 |=> $stable(groupId) [*3])
    else $error("group changed on reject");
  c_group: cover property (grp ##1 execute);
  c_reject: cover property (rangeReject);
  c_txalarm: cover property (alarmCode == ssg_pkg::ALM_TRANSMISSION);
endmodule
bind ssg_monitor ssg_monitor_props u_props (
  .clk_sys(clk_sys),
  .rst(rst),
  .stationAddr(stationAddr),
  .initialGroup(initialGroup),
  .baudSwitch(baudSwitch),
  .errThreshold(errThreshold),
  .timeoutCycles(timeoutCycles),
  .silentCycles(silentCycles),
  .replyWaitCycles(replyWaitCycles),
  .query(query),
  .txError(txError),
  .result(result),
  .logIndex(logIndex),
  .execute(execute),
  .replyEnable(replyEnable),
  .rangeReject(rangeReject),
  .actionApply(actionApply),
  .groupId(groupId),
  .logData(logData),
  .logCount(logCount),
  .alarmCode(alarmCode),
  .alarmOutput(alarmOutput),
  .motorStop(motorStop),
  .leds(leds)
);

// ===== sim/ssg_master.sv
// behavioural bus master issuing queries and line errors
`timescale 1ns/10ps
module ssg_master (
  input wire logic clk_sys,
  output ssg_pkg::ssg_query_t query,
  output logic txError
);
  initial begin
    query = '0;
    txError = 1'b0;
  end
  // group id written as one two-register unit
  task automatic send(input logic [7:0] st, fn, input logic [15:0] ad,
    input logic [31:0] dt, input logic wr, act);
    query.station = st;
    query.func = fn;
    query.regAddr = ad;
    query.regCount = 16'h0002;
    query.data = dt;
    query.isWrite = wr;
    query.action = act;
    query.valid = 1'b1;
    @(posedge clk_sys);
    @(negedge clk_sys);
    query.valid = 1'b0;
    query.data = ~dt;
  endtask
  task automatic line_error();
    txError = 1'b1;
    @(posedge clk_sys);
    @(negedge clk_sys);
    txError = 1'b0;
    @(negedge clk_sys);
  endtask
endmodule

// ===== sim/tb_top.sv
// self-checking bench for the group and alarm monitor
`timescale 1ns/10ps
module tb_top;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [7:0] stationAddr = 8'h05;
  logic [31:0] initialGroup = 32'h00000003;
  logic [3:0] baudSwitch = 4'h2;
  logic [7:0] errThreshold = 8'h00;
  logic [31:0] timeoutCycles = 32'h0;
  logic [31:0] silentCycles = 32'h0000000A;
  logic [31:0] replyWaitCycles = 32'h00000005;
  logic [3:0] logIndex = 4'h0;
  ssg_pkg::ssg_query_t query;
  ssg_pkg::ssg_result_t result = '0;
  ssg_pkg::ssg_leds_t leds;
  logic txError, execute, replyEnable, rangeReject, actionApply;
  logic alarmOutput, motorStop;
  logic [31:0] groupId;
  logic [7:0] logData, alarmCode;
  logic [3:0] logCount;
  int numErrors = 0;
  int testsRun = 0;
  int exN, rpN, rjN;
  always #12.5 clk_sys = ~clk_sys;
  ssg_master mst (
    .clk_sys(clk_sys),
    .query(query),
    .txError(txError)
  );
  ssg_monitor dut (
    .clk_sys(clk_sys),
    .rst(rst),
    .stationAddr(stationAddr),
    .initialGroup(initialGroup),
    .baudSwitch(baudSwitch),
    .errThreshold(errThreshold),
    .timeoutCycles(timeoutCycles),
    .silentCycles(silentCycles),
    .replyWaitCycles(replyWaitCycles),
    .query(query),
    .txError(txError),
    .result(result),
    .logIndex(logIndex),
    .execute(execute),
    .replyEnable(replyEnable),
    .rangeReject(rangeReject),
    .actionApply(actionApply),
    .groupId(groupId),
    .logData(logData),
    .logCount(logCount),
    .alarmCode(alarmCode),
    .alarmOutput(alarmOutput),
    .motorStop(motorStop),
    .leds(leds)
  );
  task automatic chk(input logic [31:0] got, exp);
    testsRun++;
    if (got !== exp) begin
      numErrors++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic do_reset();
    rst = 1'b1;
    repeat (16) @(negedge clk_sys);
    rst = 1'b0;
    repeat (3) @(negedge clk_sys);
  endtask
  // first cycle after the query at which each pulse shows
  task automatic watch();
    exN = 0;
    rpN = 0;
    rjN = 0;
    for (int n = 1; n <= 30; n++) begin
      if (execute === 1'b1 && exN == 0) exN = n;
      if (replyEnable === 1'b1 && rpN == 0) rpN = n;
      if (rangeReject === 1'b1 && rjN == 0) rjN = n;
      @(negedge clk_sys);
    end
  endtask
  task automatic test_group();
    logic [31:0] bad [2] = '{32'h0, 32'h00000020};
    chk(groupId, 32'h00000003);
    chk(logCount, 4'h0);
    mst.send(8'h05, 8'h03, 16'h0030, 32'h0, 1'b0, 1'b0);
    watch();
    chk(rpN, replyWaitCycles + silentCycles + 3);
    mst.send(8'h05, 8'h10, 16'h0030, 32'h00000009, 1'b1, 1'b0);
    watch();
    chk(groupId, 32'h00000009);
    mst.send(8'h09, 8'h10, 16'h0100, 32'h00000001, 1'b1, 1'b0);
    watch();
    chk(exN, 1);
    chk(rpN, 0);
    mst.send(8'h09, 8'h03, 16'h0100, 32'h0, 1'b0, 1'b0);
    watch();
    chk(exN, 0);
    foreach (bad[i]) begin
      mst.send(8'h05, 8'h10, 16'h0030, bad[i], 1'b1, 1'b0);
      watch();
      chk(rjN > 0, 1'b1);
      chk(groupId, 32'h00000009);
      chk(logData, ssg_pkg::ERR_RANGE);
    end
    mst.send(8'h05, 8'h10, 16'h0030, ssg_pkg::GROUP_NONE, 1'b1, 1'b0);
    watch();
    chk(groupId, ssg_pkg::GROUP_NONE);
    $display("group test done");
  endtask
  task automatic test_action();
    int n;
    n = 0;
    mst.send(8'h05, 8'h10, 16'h0100, 32'h00000001, 1'b1, 1'b1);
    while (actionApply !== 1'b1 && n < 10 + ssg_pkg::ACTION_EXTRA_CYC) begin
      @(negedge clk_sys);
      n++;
    end
    chk(actionApply, 1'b1);
    $display("action test done");
  endtask
  task automatic test_log();
    logic [7:0] xc [6] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h04, 8'h04};
    logic [2:0] fl [6] = '{3'h0, 3'h0, 3'h0, 3'h4, 3'h2, 3'h1};
    logic [7:0] ex [6] = '{8'h88, 8'h88, 8'h8C, 8'h8A, 8'h89, 8'h8D};
    for (int i = 0; i < 6; i++) begin
      result = '{1'b1, 1'b1, xc[i], fl[i][2], fl[i][1], fl[i][0]};
      @(negedge clk_sys);
      result = '0;
      repeat (3) @(negedge clk_sys);
      chk(logData, ex[i]);
    end
    chk(logCount, 4'h8);
    chk(leds, 3'h0);
    $display("log test done");
  endtask
  task automatic test_alarms();
    errThreshold = 8'h03;
    repeat (2) mst.line_error();
    repeat (3) @(negedge clk_sys);
    chk(leds.commRed, 1'b1);
    chk(alarmCode, ssg_pkg::ALM_NONE);
    mst.line_error();
    repeat (3) @(negedge clk_sys);
    chk(alarmCode, ssg_pkg::ALM_TRANSMISSION);
    chk({alarmOutput, motorStop}, 2'b01);
    errThreshold = 8'h00;
    timeoutCycles = 32'h00000032;
    do_reset();
    repeat (44) @(negedge clk_sys);
    chk(alarmCode, ssg_pkg::ALM_NONE);
    repeat (10) @(negedge clk_sys);
    chk(alarmCode, ssg_pkg::ALM_TIMEOUT);
    timeoutCycles = 32'h0;
    baudSwitch = 4'h6;
    do_reset();
    chk(alarmCode, ssg_pkg::ALM_SWITCH);
    baudSwitch = 4'h5;
    do_reset();
    chk(alarmCode, ssg_pkg::ALM_NONE);
    $display("alarm test done");
  endtask
  task automatic final_report();
    $display("checks %0d, mismatches %0d", testsRun, numErrors);
    if (numErrors == 0 && testsRun > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // action wait may run to the full 2 ms budget
  initial begin
    #2500000;
    numErrors++;
    final_report();
  end
  initial begin
    do_reset();
    test_group();
    test_action();
    test_log();
    test_alarms();
    final_report();
  end
endmodule
